// File: rtl/clh_top.sv
// Purpose: Host port, initialisation tracking and panel timing of an LCD
//          character controller, with a Wishbone status and control slave.
// Assumes: Host pins are asynchronous; 125 MHz clock; synchronous reset.
// Notes:   No summary of operation is given.
`timescale 1ns/1ps
module clh_top
    import clh_pkg::*;
#(
    parameter int unsigned OSC_DIV_P = OSC_DIV
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic        enable_strobe_i,
    input  wire logic        register_select_i,
    input  wire logic        read_write_i,
    input  wire logic [7:0]  host_data_lines_i,
    output logic      [7:0]  host_data_lines_o,
    output logic             host_data_lines_oe_o,
    output logic      [15:0] common_drive_o,
    output logic      [39:0] segment_drive_o,
    output logic             frame_alternation_o,
    output logic             latch_pulse_o
);
    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    clh_sync_if #(.WIDTH(11)) sif ();
    assign sif.raw = {enable_strobe_i, register_select_i, read_write_i,
                      host_data_lines_i};
    clh_sync #(.WIDTH(11)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .port  (sif.snk)
    );
    logic       e_s, rs_s, rw_s;
    logic [7:0] d_s;
    assign {e_s, rs_s, rw_s, d_s} = sif.sync;

    // ------------------------------------------------------------------
    // Host port state
    // ------------------------------------------------------------------
    clh_init_e  init_reg, init_next;
    logic       e_d_reg, e_d_next;
    logic       four_reg, four_next, phase_reg, phase_next;
    logic [3:0] hi_reg, hi_next;
    logic [7:0] hold_reg, hold_next, out_reg, out_next;
    logic [7:0] data_reg, data_next;
    logic [6:0] ac_reg, ac_next;
    logic       inc_reg, inc_next, disp_reg, disp_next;
    logic       lines_reg, lines_next, font_reg, font_next;
    logic [8:0] busy_cnt_reg, busy_cnt_next;
    logic [8:0] osc_cnt_reg, osc_cnt_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic       busy, osc_tick, port_en, e_rise, e_fall, complete;
    logic [7:0] byte_in, rd_byte;
    logic [6:0] ac_step;

    assign busy     = (busy_cnt_reg != 9'h000);
    assign osc_tick = (osc_cnt_reg == 9'(OSC_DIV_P - 1));
    assign port_en  = ctrl_reg[CTRL_EN_BIT];
    assign e_rise   = e_s & ~e_d_reg & port_en;
    assign e_fall   = ~e_s & e_d_reg & port_en;
    assign complete = ~four_reg | phase_reg;
    assign byte_in  = four_reg ? {hi_reg, d_s[7:4]} : d_s;
    assign ac_step  = inc_reg ? ac_reg + 7'h01 : ac_reg - 7'h01;
    assign rd_byte  = rs_s ? data_reg : {busy, ac_reg};

    always_comb begin
        init_next     = init_reg;
        e_d_next      = e_s;
        four_next     = four_reg;
        phase_next    = phase_reg;
        hi_next       = hi_reg;
        hold_next     = hold_reg;
        out_next      = out_reg;
        data_next     = data_reg;
        ac_next       = ac_reg;
        inc_next      = inc_reg;
        disp_next     = disp_reg;
        lines_next    = lines_reg;
        font_next     = font_reg;
        osc_cnt_next  = osc_tick ? 9'h000 : osc_cnt_reg + 9'h001;
        busy_cnt_next = (busy && osc_tick) ? busy_cnt_reg - 9'h001
                                           : busy_cnt_reg;
        if (e_rise && rw_s) begin
            if (!four_reg) begin
                out_next = rd_byte;
            end else if (!phase_reg) begin
                hold_next = rd_byte;
                out_next  = {rd_byte[7:4], 4'h0};
            end else begin
                out_next  = {hold_reg[3:0], 4'h0};
            end
        end
        if (e_fall) begin
            if (four_reg) begin
                phase_next = ~phase_reg;
                if (!phase_reg) begin
                    hi_next = d_s[7:4];
                end
            end
            if (complete && rw_s) begin
                if (rs_s) begin
                    ac_next = ac_step;
                end
            end else if (complete && !busy) begin
                if (rs_s) begin
                    data_next = byte_in;
                    ac_next   = ac_step;
                end else begin
                    busy_cnt_next = 9'(EXEC_TICKS);
                    if (byte_in == CMD_CLEAR) begin
                        ac_next       = 7'h00;
                        busy_cnt_next = 9'(CLEAR_TICKS);
                    end else if (byte_in[7]) begin
                        ac_next = byte_in[6:0];
                    end else if (byte_in[7:5] == CMD_FUNC_TOP) begin
                        case (init_reg)
                            CLH_POWERUP, CLH_FIRST, CLH_SECOND: begin
                                four_next = 1'b0;
                                if (byte_in[7:4] == IFACE_NIBBLE) begin
                                    init_next = (init_reg == CLH_POWERUP)
                                        ? CLH_FIRST
                                        : (init_reg == CLH_FIRST)
                                        ? CLH_SECOND : CLH_READY;
                                end
                            end
                            CLH_READY: begin
                                four_next = ~byte_in[4];
                                if (four_reg || byte_in[4]) begin
                                    lines_next = byte_in[3];
                                    font_next  = byte_in[2];
                                    init_next  = CLH_LOCKED;
                                end
                            end
                            CLH_LOCKED: begin
                                four_next = ~byte_in[4];
                            end
                            default: begin
                                init_next = CLH_POWERUP;
                            end
                        endcase
                        if (four_next != four_reg) begin
                            phase_next = 1'b0;
                        end
                    end else if (byte_in[7:3] == CMD_DISP_TOP) begin
                        disp_next = byte_in[2];
                    end else if (byte_in[7:2] == CMD_SHIFT_TOP) begin
                        inc_next = byte_in[1];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_reg     <= CLH_POWERUP;
            e_d_reg      <= 1'b0;
            four_reg     <= 1'b0;
            phase_reg    <= 1'b0;
            hi_reg       <= 4'h0;
            hold_reg     <= 8'h00;
            out_reg      <= 8'h00;
            data_reg     <= 8'h00;
            ac_reg       <= 7'h00;
            inc_reg      <= 1'b1;
            disp_reg     <= 1'b0;
            lines_reg    <= 1'b0;
            font_reg     <= 1'b0;
            busy_cnt_reg <= 9'h000;
            osc_cnt_reg  <= 9'h000;
        end else begin
            init_reg     <= init_next;
            e_d_reg      <= e_d_next;
            four_reg     <= four_next;
            phase_reg    <= phase_next;
            hi_reg       <= hi_next;
            hold_reg     <= hold_next;
            out_reg      <= out_next;
            data_reg     <= data_next;
            ac_reg       <= ac_next;
            inc_reg      <= inc_next;
            disp_reg     <= disp_next;
            lines_reg    <= lines_next;
            font_reg     <= font_next;
            busy_cnt_reg <= busy_cnt_next;
            osc_cnt_reg  <= osc_cnt_next;
        end
    end

    assign host_data_lines_o    = out_reg;
    assign host_data_lines_oe_o = e_s & e_d_reg & rw_s & port_en;

    // ------------------------------------------------------------------
    // Panel timing
    // ------------------------------------------------------------------
    logic [8:0]  rtick_reg, rtick_next, row_ticks;
    logic [3:0]  row_reg, row_next, rows_m1;
    logic        falt_reg, falt_next, latch_reg, latch_next;
    logic [15:0] com_reg, com_next;
    logic [39:0] seg_reg, seg_next;

    always_comb begin
        row_ticks  = lines_reg ? 9'(ROW_TICKS_D16)
                   : font_reg  ? 9'(ROW_TICKS_D11) : 9'(ROW_TICKS_D8);
        rows_m1    = lines_reg ? 4'(ROWS_D16 - 1)
                   : font_reg  ? 4'(ROWS_D11 - 1) : 4'(ROWS_D8 - 1);
        rtick_next = rtick_reg;
        row_next   = row_reg;
        falt_next  = falt_reg;
        latch_next = 1'b0;
        if (osc_tick) begin
            if (rtick_reg >= row_ticks - 9'h001) begin
                rtick_next = 9'h000;
                latch_next = 1'b1;
                if (row_reg >= rows_m1) begin
                    row_next  = 4'h0;
                    falt_next = ~falt_reg;
                end else begin
                    row_next = row_reg + 4'h1;
                end
            end else begin
                rtick_next = rtick_reg + 9'h001;
            end
        end
        // Restart the row when the duty is latched, so the count fits it.
        if (init_next == CLH_LOCKED && init_reg != CLH_LOCKED) begin
            rtick_next = 9'h000;
            row_next   = 4'h0;
        end
        com_next = 16'h0001 << row_next;
        seg_next = (disp_reg ? {5{data_reg}} : 40'h00_0000_0000)
                 ^ {40{falt_next}};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rtick_reg <= 9'h000;
            row_reg   <= 4'h0;
            falt_reg  <= 1'b0;
            latch_reg <= 1'b0;
            com_reg   <= 16'h0001;
            seg_reg   <= 40'h00_0000_0000;
        end else begin
            rtick_reg <= rtick_next;
            row_reg   <= row_next;
            falt_reg  <= falt_next;
            latch_reg <= latch_next;
            com_reg   <= com_next;
            seg_reg   <= seg_next;
        end
    end

    assign common_drive_o      = com_reg;
    assign segment_drive_o     = seg_reg;
    assign frame_alternation_o = falt_reg;
    assign latch_pulse_o       = latch_reg;

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    logic        ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next, status;

    always_comb begin
        status = 32'h0000_0000;
        status[ST_AC_LSB +: 7]   = ac_reg;
        status[ST_BUSY_BIT]      = busy;
        status[ST_FOUR_BIT]      = four_reg;
        status[ST_LINES_BIT]     = lines_reg;
        status[ST_FONT_BIT]      = font_reg;
        status[ST_DISP_BIT]      = disp_reg;
        status[ST_INIT_LSB +: 3] = init_reg;
        ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
        ctrl_next = ctrl_reg;
        rdat_next = rdat_reg;
        if (ack_next) begin
            rdat_next = 32'h0000_0000;
            if (wb_adr_i == REG_CTRL_OFS) begin
                rdat_next = ctrl_reg;
                if (wb_we_i && wb_sel_i[0]) begin
                    ctrl_next[0] = wb_dat_i[CTRL_EN_BIT];
                end
            end else if (wb_adr_i == REG_STATUS_OFS) begin
                rdat_next = status;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            ctrl_reg <= CTRL_RESET_VAL;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg  <= ack_next;
            ctrl_reg <= ctrl_next;
            rdat_reg <= rdat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_status_start;
        e_rise && rw_s && !rs_s && four_reg && !phase_reg;
    endsequence

    a_row_bound: assert property (rtick_reg < row_ticks)
        else $error("Row tick counter past row length.");
    a_frame_flip: assert property (
        $changed(falt_reg) |-> latch_reg && row_reg == 4'h0)
        else $error("Frame alternation changed off a frame end.");
    a_common_row: assert property (
        $onehot(com_reg) && row_reg <= rows_m1)
        else $error("Common drive not one row within duty.");
    a_latch_single: assert property (latch_reg |=> !latch_reg)
        else $error("Latch pulse longer than one cycle.");
    a_lock_fixed: assert property (
        init_reg == CLH_LOCKED |=> init_reg == CLH_LOCKED
        && $stable(lines_reg) && $stable(font_reg))
        else $error("Line count or font changed after lock.");
    a_nibble_pair: assert property (
        four_reg && e_fall && !phase_reg |=> phase_reg)
        else $error("Four-bit access not split into two nibbles.");
    a_status_nib: assert property (
        s_status_start |=> out_reg[7] == $past(busy)
        && out_reg[6:4] == $past(ac_reg[6:4]))
        else $error("First status nibble wrong.");
    a_busy_ignore: assert property (
        busy && e_fall && complete && !rw_s && busy_cnt_reg > 9'h001
        |=> busy && $stable(disp_reg) && $stable(data_reg)
        && $stable(init_reg))
        else $error("Write accepted while busy.");
    a_busy_start: assert property (
        !busy && e_fall && complete && !rw_s && !rs_s |=> busy)
        else $error("Accepted instruction did not raise busy.");
endmodule

// File: include/clh_pkg.sv
// Purpose: Shared constants and types of the character LCD host port.
// Assumes: System clock of 125 MHz; internal oscillator of 270 kHz.
// Notes:   Times are kept in their own unit; cycle counts derive from them, save CLEAR_TICKS, given in ticks.
package clh_pkg;

    // ------------------------------------------------------------------
    // Clocking and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 125_000_000;
    localparam int unsigned OSC_HZ      = 270_000;
    localparam int unsigned OSC_DIV     = (CLK_HZ + OSC_HZ / 2) / OSC_HZ;
    localparam int unsigned EXEC_US     = 37;
    localparam int unsigned EXEC_TICKS  =
        (EXEC_US * OSC_HZ + 999_999) / 1_000_000;
    localparam int unsigned CLEAR_TICKS = 410;

    // Frame rates in millihertz, and the oscillator ticks of one common row.
    localparam int unsigned FRAME_MHZ_D8  = 84_300;
    localparam int unsigned FRAME_MHZ_D11 = 61_400;
    localparam int unsigned FRAME_MHZ_D16 = 84_300;
    localparam int unsigned ROWS_D8       = 8;
    localparam int unsigned ROWS_D11      = 11;
    localparam int unsigned ROWS_D16      = 16;
    localparam int unsigned ROW_TICKS_D8  =
        (OSC_HZ * 1000 + FRAME_MHZ_D8 * ROWS_D8 / 2) / (FRAME_MHZ_D8 * ROWS_D8);
    localparam int unsigned ROW_TICKS_D11 =
        (OSC_HZ * 1000 + FRAME_MHZ_D11 * ROWS_D11 / 2)
        / (FRAME_MHZ_D11 * ROWS_D11);
    localparam int unsigned ROW_TICKS_D16 =
        (OSC_HZ * 1000 + FRAME_MHZ_D16 * ROWS_D16 / 2)
        / (FRAME_MHZ_D16 * ROWS_D16);

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  REG_STATUS_OFS = 8'h04;
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0001;
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned ST_AC_LSB      = 0;
    localparam int unsigned ST_BUSY_BIT    = 7;
    localparam int unsigned ST_FOUR_BIT    = 8;
    localparam int unsigned ST_LINES_BIT   = 9;
    localparam int unsigned ST_FONT_BIT    = 10;
    localparam int unsigned ST_DISP_BIT    = 11;
    localparam int unsigned ST_INIT_LSB    = 16;

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR     = 8'h01;
    localparam logic [2:0] CMD_FUNC_TOP  = 3'h1;
    localparam logic [4:0] CMD_DISP_TOP  = 5'h01;
    localparam logic [5:0] CMD_SHIFT_TOP = 6'h01;
    localparam logic [3:0] IFACE_NIBBLE  = 4'h3;

    typedef enum logic [2:0] {
        CLH_POWERUP = 3'h0,
        CLH_FIRST   = 3'h1,
        CLH_SECOND  = 3'h3,
        CLH_READY   = 3'h2,
        CLH_LOCKED  = 3'h6
    } clh_init_e;

endpackage

// File: include/clh_sync_if.sv
// Purpose: Carries raw pin levels to the synchroniser and back.
// Assumes: One clock domain on the synchronised side.
// Notes:   None.
`timescale 1ns/1ps
interface clh_sync_if #(
    parameter int WIDTH = 11
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] sync;
    modport src (output raw, input sync);
    modport snk (input raw, output sync);
endinterface

// File: rtl/clh_sync.sv
// Purpose: Two-flop synchroniser for asynchronous host pins.
// Assumes: Synchronous active-high reset.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module clh_sync #(
    parameter int WIDTH = 11
) (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    clh_sync_if.snk     port
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = port.raw;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign port.sync = sync_reg;
endmodule

// File: bench/clh_host_model.sv
// Purpose: Host controller model driving the LCD host port pins.
// Assumes: Host waits are divided by SCALE to keep the run short.
// Notes:   A read releases the bus, which then shows its inverted value.
`timescale 1ns/1ps
module clh_host_model #(
    parameter int unsigned SCALE = 1000
) (
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_i,
    output logic            e_o,
    output logic            rs_o,
    output logic            rw_o,
    output logic      [7:0] drv_o
);
    initial {e_o, rs_o, rw_o, drv_o} = 11'h000;
    // Counts round up so that every wait meets its minimum.
    task automatic wt(input int unsigned us);
        repeat ((us * 125 + SCALE - 1) / SCALE) @(posedge clk_i);
    endtask
    task automatic strobe(input logic rw, input logic rs, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk_i);
        {rs_o, rw_o, drv_o} <= {rs, rw, rw ? ~drv_o : d};
        @(posedge clk_i);
        e_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        q = pin_i;
        e_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic wr(input logic four, input logic rs, input logic [7:0] d);
        logic [7:0] q;
        strobe(1'b0, rs, four ? {d[7:4], ~d[7:4]} : d, q);
        if (four) strobe(1'b0, rs, {d[3:0], ~d[3:0]}, q);
    endtask
    task automatic rd(input logic four, output logic [7:0] q);
        logic [7:0] h, l;
        strobe(1'b1, 1'b0, 8'h00, h);
        strobe(1'b1, 1'b0, 8'h00, l);
        q = four ? {h[7:4], l[7:4]} : h;
    endtask
    task automatic poll(input logic four, output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 400 && !ok; i++) begin
            rd(four, s);
            ok = (s[7] === 1'b0);
        end
    endtask
endmodule

// File: bench/tb_top.sv
// Purpose: Self-checking bench of the LCD host port and panel timing.
// Assumes: Oscillator divider of 2; host waits scaled down.
// Notes:   Registers are reached through classic Wishbone cycles.
`timescale 1ns/1ps
module tb_top
    import clh_pkg::*;
;
    localparam int unsigned DIV = 2;
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic        e, rs, rw, oe, fa, lp, ok;
    logic [3:0]  wb_sel_i;
    logic [7:0]  wb_adr_i, drv, dout, pin, s;
    logic [15:0] common_drive;
    logic [31:0] wb_dat_i, wb_dat_o, w;
    logic [39:0] segment_drive;
    int          mismatches, tests_run, k, c;
    assign pin = oe ? dout : drv;
    clh_top #(.OSC_DIV_P(DIV)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_ack_o(wb_ack_o), .enable_strobe_i(e), .register_select_i(rs),
        .read_write_i(rw), .host_data_lines_i(pin),
        .host_data_lines_o(dout), .host_data_lines_oe_o(oe),
        .common_drive_o(common_drive), .segment_drive_o(segment_drive),
        .frame_alternation_o(fa), .latch_pulse_o(lp));
    clh_host_model hm (.clk_i(clk_i), .pin_i(pin), .e_o(e),
        .rs_o(rs), .rw_o(rw), .drv_o(drv));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic we,
                      input logic [31:0] d, output logic [31:0] q);
        int t;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        t = 0;
        do @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && ++t < 50);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        chk("ack", 32'h1, 32'(wb_ack_o));
    endtask
    task automatic stf(input string nm, input int unsigned lsb,
                       input int unsigned wd, input logic [31:0] ex);
        logic [31:0] v;
        wb(REG_STATUS_OFS, 1'b0, 32'h0, v);
        chk(nm, ex, (v >> lsb) & ((32'h1 << wd) - 32'h1));
    endtask
    task automatic cmd(input logic r, input logic [7:0] d);
        hm.wr(1'b1, r, d);
        hm.poll(1'b1, ok);
        chk("idle", 32'h1, 32'(ok));
    endtask
    // Counts cycles and row pulses from the call up to the next frame flip.
    task automatic frame();
        logic f;
        f = fa;
        {k, c} = 64'h0;
        for (int i = 0; i < 20000 && fa === f; i++) begin
            @(posedge clk_i);
            c++;
            k += int'(lp === 1'b1);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_adr_i, wb_dat_i, wb_sel_i} = {8'h00, 32'h0, 4'hF};
        {mismatches, tests_run} = 64'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        wb(REG_CTRL_OFS, 1'b0, 32'h0, w);
        chk("ctrl", CTRL_RESET_VAL, w);
        wb(8'h10, 1'b1, 32'hFFFF_FFFF, w);
        wb(8'h10, 1'b0, 32'h0, w);
        chk("unmapped", 32'h0, w);
        wb(REG_STATUS_OFS, 1'b1, 32'hFFFF_FFFF, w);
        hm.wt(15000);
        wb(REG_CTRL_OFS, 1'b1, 32'h0, w);
        hm.wr(1'b0, 1'b0, 8'h30);
        stf("off", ST_INIT_LSB, 3, 32'(CLH_POWERUP));
        wb(REG_CTRL_OFS, 1'b1, CTRL_RESET_VAL, w);
        $display("test bus done");
        hm.wr(1'b0, 1'b0, 8'h35);
        stf("init1", ST_INIT_LSB, 3, 32'(CLH_FIRST));
        hm.wt(4100);
        hm.wr(1'b0, 1'b0, 8'h3A);
        stf("init2", ST_INIT_LSB, 3, 32'(CLH_SECOND));
        hm.wt(100);
        hm.wr(1'b0, 1'b0, 8'h3F);
        stf("init3", ST_INIT_LSB, 3, 32'(CLH_READY));
        hm.poll(1'b0, ok);
        chk("ready", 32'h1, 32'(ok));
        hm.wr(1'b0, 1'b0, 8'h20);
        hm.wt(100);
        stf("four", ST_FOUR_BIT, 1, 32'h1);
        cmd(1'b0, 8'h28);
        stf("lock", ST_INIT_LSB, 3, 32'(CLH_LOCKED));
        cmd(1'b0, 8'h24);
        stf("lines", ST_LINES_BIT, 1, 32'h1);
        stf("font", ST_FONT_BIT, 1, 32'h0);
        $display("test init done");
        cmd(1'b0, 8'h0C);
        cmd(1'b0, CMD_CLEAR);
        cmd(1'b1, 8'h41);
        hm.rd(1'b1, s);
        chk("status", 32'h1, 32'(s));
        frame();
        frame();
        chk("frame", ROWS_D16 * ROW_TICKS_D16 * DIV, 32'(c));
        chk("rows", ROWS_D16, 32'(k));
        chk("com", 32'h1, 32'($countones(common_drive)));
        repeat (2) @(posedge clk_i);
        chk("seg", 32'h4141_4141, segment_drive[31:0] ^ {32{fa}});
        $display("test panel done");
        hm.wr(1'b1, 1'b0, CMD_CLEAR);
        hm.rd(1'b1, s);
        chk("busy", 32'h1, 32'(s[7]));
        hm.wr(1'b1, 1'b0, 8'h08);
        hm.poll(1'b1, ok);
        stf("ignored", ST_DISP_BIT, 1, 32'h1);
        cmd(1'b0, 8'h08);
        stf("disp_off", ST_DISP_BIT, 1, 32'h0);
        cmd(1'b0, 8'h06);
        $display("test busy done");
        print_verdict();
    end
endmodule
